// >>> rtl/ljx_pkg.sv
// Functional notes
// - With checking on, result above upper is high, inside inclusive pass, below lower low.
// - With checking off, no high, pass or low judgement is produced.
// - Buzzer mode high, pass, low or off; sounds only on matching latest judgement.
// - Operate-off input: rising line edge forces standby; the line never selects operate.
// - Operate on/off input: rising edge gives standby, falling edge gives operate.
// - Interlock: rising edge forces standby; line high refuses key or bus operate.
// - Operate-out: line driven low in operate, high in standby.
// - Start-pulse function: one low pulse when each measurement begins.
// - End-pulse function: one low pulse after measurement and period both complete.
// - Judgement function: one low pulse when judgement equals selected outcome.
// - Busy input low stalls measurement and sweep start; resumes when high.
// - Busy output low from source delay start until period and measurement complete.
// - Pulse width selectable: short about 20 to 30 us, long 100 to 200 us.
package ljx_pkg;
  localparam int CLK_MHZ = 125;
  localparam int SHORT_PULSE_US = 20;
  localparam int LONG_PULSE_US = 100;
  localparam int SHORT_PULSE_CYC = SHORT_PULSE_US * CLK_MHZ;
  localparam int LONG_PULSE_CYC = LONG_PULSE_US * CLK_MHZ;
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_UPPER = 6'h04;
  localparam logic [5:0] OFF_LOWER = 6'h08;
  localparam logic [5:0] OFF_RESULT = 6'h0c;
  localparam logic [5:0] OFF_STAT = 6'h10;
  localparam logic [5:0] OFF_IRQ_ST = 6'h14;
  localparam logic [5:0] OFF_IRQ_MASK = 6'h18;
  localparam logic [5:0] OFF_CMD = 6'h1c;
  // Control field positions
  localparam int CTL_CMP_EN = 0;
  localparam int CTL_BUZ_LSB = 1;
  localparam int CTL_OPF_LSB = 4;
  localparam int CTL_CBF_LSB = 8;
  localparam int CTL_WIDE = 12;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // Command bits
  localparam int CMD_OPERATE = 0;
  localparam int CMD_STANDBY = 1;
  // Interrupt bits
  localparam int IRQ_JUDGE = 0;
  localparam int IRQ_STBY = 1;
  localparam int IRQ_CPULSE = 2;
  localparam int IRQ_REFUSE = 3;
  localparam int IRQ_W = 4;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {J_NONE, J_HIGH, J_PASS, J_LOW} ljx_judge_e;
  typedef enum logic [1:0] {BZ_HIGH, BZ_PASS, BZ_LOW, BZ_OFF} ljx_buz_e;
  typedef enum logic [1:0] {OP_OFF_IN, OP_ONOFF_IN, OP_ILOCK_IN, OP_OUT} ljx_opf_e;
  typedef enum logic [2:0] {
    CB_START, CB_END, CB_HIGH, CB_PASS, CB_LOW, CB_BUSY_IN, CB_BUSY_OUT, CB_RSVD
  } ljx_cbf_e;
endpackage

// >>> rtl/ljx_pulse.sv
module ljx_pulse
  import ljx_pkg::*;
#(
  parameter int SHORT_CYC = SHORT_PULSE_CYC,
  parameter int LONG_CYC = LONG_PULSE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fire,
  input wire logic wide,
  output logic active
);
  import ljx_pkg::*;
  localparam int CW = $clog2(LONG_CYC + 1);
  logic [CW-1:0] cnt_r;

  // Retriggerable one-shot, width chosen at trigger
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (fire) begin
      cnt_r <= wide ? CW'(LONG_CYC) : CW'(SHORT_CYC);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - CW'(1);
    end
  end

  assign active = (cnt_r != '0);
endmodule

// >>> rtl/ljx_top.sv
// The placing of the registers and the AXI4-Lite slave port were decided locally.
module ljx_top #(
  parameter int SHORT_CYC = ljx_pkg::SHORT_PULSE_CYC,
  parameter int LONG_CYC = ljx_pkg::LONG_PULSE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic result_valid,
  input wire logic [31:0] result_data,
  input wire logic key_operate,
  input wire logic meas_start,
  input wire logic meas_done,
  input wire logic period_done,
  input wire logic src_delay_start,
  input wire logic ilock_in,
  output logic ilock_out,
  output logic ilock_oe,
  input wire logic cmpl_in,
  output logic cmpl_out,
  output logic cmpl_oe,
  output logic operate,
  output logic meas_allow,
  output logic buzzer,
  output logic above_upper_limit,
  output logic pass_limits,
  output logic below_lower_limit,
  output logic irq
);
  import ljx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  logic [31:0] ctrl_r;
  logic [31:0] upper_r;
  logic [31:0] lower_r;
  logic [IRQ_W-1:0] irq_st_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [5:0] awaddr_r;
  logic aw_have_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_have_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic wr_go;
  logic bus_operate;
  logic bus_standby;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction

  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready = !w_have_r && !bvalid_r;
  assign wr_go = aw_have_r && w_have_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign bus_operate = wr_go && awaddr_r == OFF_CMD && wstrb_r[0] && wdata_r[CMD_OPERATE];
  assign bus_standby = wr_go && awaddr_r == OFF_CMD && wstrb_r[0] && wdata_r[CMD_STANDBY];

  // Address and data capture, either order
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[5:2], 2'b00};
      end else if (wr_go) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        w_have_r <= 1'b0;
      end
    end
  end

  // Register writes and write response
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RST;
      upper_r <= '0;
      lower_r <= '0;
      irq_mask_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= RESP_OKAY;
        case (awaddr_r)
          OFF_CTRL: ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r);
          OFF_UPPER: upper_r <= merge(upper_r, wdata_r, wstrb_r);
          OFF_LOWER: lower_r <= merge(lower_r, wdata_r, wstrb_r);
          OFF_IRQ_MASK: irq_mask_r <= wstrb_r[0] ? wdata_r[IRQ_W-1:0] : irq_mask_r;
          OFF_IRQ_ST, OFF_CMD: bresp_r <= RESP_OKAY;
          default: bresp_r <= RESP_SLVERR;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration fields

  logic cmp_en;
  ljx_buz_e buz_mode;
  ljx_opf_e op_fn;
  ljx_cbf_e cb_fn;
  logic wide;

  assign cmp_en = ctrl_r[CTL_CMP_EN];
  assign buz_mode = ljx_buz_e'(ctrl_r[CTL_BUZ_LSB +: 2]);
  assign op_fn = ljx_opf_e'(ctrl_r[CTL_OPF_LSB +: 2]);
  assign cb_fn = ljx_cbf_e'(ctrl_r[CTL_CBF_LSB +: 3]);
  assign wide = ctrl_r[CTL_WIDE];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [1:0] ilock_sync_r;
  logic [1:0] cmpl_sync_r;
  logic ilock_prev_r;
  logic ilock_s;
  logic cmpl_s;
  logic ilock_rise;
  logic ilock_fall;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ilock_sync_r <= 2'b11;
      cmpl_sync_r <= 2'b11;
      ilock_prev_r <= 1'b1;
    end else begin
      ilock_sync_r <= {ilock_sync_r[0], ilock_in};
      cmpl_sync_r <= {cmpl_sync_r[0], cmpl_in};
      ilock_prev_r <= ilock_sync_r[1];
    end
  end

  assign ilock_s = ilock_sync_r[1];
  assign cmpl_s = cmpl_sync_r[1];
  assign ilock_rise = op_fn != OP_OUT && ilock_s && !ilock_prev_r;
  assign ilock_fall = op_fn != OP_OUT && !ilock_s && ilock_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // Limit judgement

  ljx_judge_e judge_r;
  ljx_judge_e judge_nxt;
  logic judge_ev_r;

  always_comb begin
    if (!cmp_en) begin
      judge_nxt = J_NONE;
    end else if ($signed(result_data) > $signed(upper_r)) begin
      judge_nxt = J_HIGH;
    end else if ($signed(result_data) < $signed(lower_r)) begin
      judge_nxt = J_LOW;
    end else begin
      judge_nxt = J_PASS;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      judge_r <= J_NONE;
      judge_ev_r <= 1'b0;
    end else begin
      judge_ev_r <= result_valid && cmp_en;
      if (!cmp_en) begin
        judge_r <= J_NONE;
      end else if (result_valid) begin
        judge_r <= judge_nxt;
      end
    end
  end

  assign above_upper_limit = judge_r == J_HIGH;
  assign pass_limits = judge_r == J_PASS;
  assign below_lower_limit = judge_r == J_LOW;

  always_comb begin
    case (buz_mode)
      BZ_HIGH: buzzer = judge_r == J_HIGH;
      BZ_PASS: buzzer = judge_r == J_PASS;
      BZ_LOW: buzzer = judge_r == J_LOW;
      default: buzzer = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operate and standby

  logic operate_r;
  logic op_req;
  logic refuse;
  logic go_standby;

  assign op_req = key_operate || bus_operate;
  assign refuse = op_fn == OP_ILOCK_IN && ilock_s && op_req;
  assign go_standby = ilock_rise || bus_standby;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      operate_r <= 1'b0;
    end else if (go_standby) begin
      operate_r <= 1'b0;
    end else if (op_fn == OP_ONOFF_IN && ilock_fall) begin
      operate_r <= 1'b1;
    end else if (op_req && !refuse) begin
      operate_r <= 1'b1;
    end
  end

  assign operate = operate_r;
  assign ilock_oe = op_fn == OP_OUT;
  assign ilock_out = !operate_r;

  ////////////////////////////////////////////////////////////////////////////
  // Complete and busy line

  logic fire;
  logic pulse_act;
  logic busy_r;

  always_comb begin
    case (cb_fn)
      CB_START: fire = meas_start;
      CB_END: fire = meas_done && period_done;
      CB_HIGH: fire = judge_ev_r && judge_r == J_HIGH;
      CB_PASS: fire = judge_ev_r && judge_r == J_PASS;
      CB_LOW: fire = judge_ev_r && judge_r == J_LOW;
      default: fire = 1'b0;
    endcase
  end

  ljx_pulse #(
    .SHORT_CYC(SHORT_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_pulse (
    .clk(clk),
    .rst_n(rst_n),
    .fire(fire),
    .wide(wide),
    .active(pulse_act)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
    end else if (src_delay_start) begin
      busy_r <= 1'b1;
    end else if (meas_done && period_done) begin
      busy_r <= 1'b0;
    end
  end

  assign cmpl_oe = cb_fn != CB_BUSY_IN && cb_fn != CB_RSVD;
  assign cmpl_out = cb_fn == CB_BUSY_OUT ? !busy_r : !pulse_act;
  assign meas_allow = !(cb_fn == CB_BUSY_IN && !cmpl_s);

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts and reads

  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] irq_clr;

  assign irq_ev[IRQ_JUDGE] = judge_ev_r;
  assign irq_ev[IRQ_STBY] = go_standby && operate_r;
  assign irq_ev[IRQ_CPULSE] = fire;
  assign irq_ev[IRQ_REFUSE] = refuse;
  assign irq_clr = (wr_go && awaddr_r == OFF_IRQ_ST && wstrb_r[0]) ?
                   wdata_r[IRQ_W-1:0] : '0;

  // Set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_st_r <= '0;
    end else begin
      irq_st_r <= (irq_st_r & ~irq_clr) | irq_ev;
    end
  end

  assign irq = |(irq_st_r & irq_mask_r);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r <= RESP_OKAY;
      case ({s_axi_araddr[5:2], 2'b00})
        OFF_CTRL: rdata_r <= ctrl_r;
        OFF_UPPER: rdata_r <= upper_r;
        OFF_LOWER: rdata_r <= lower_r;
        OFF_RESULT: rdata_r <= {30'h0, judge_r};
        OFF_STAT: rdata_r <= {26'h0, busy_r, pulse_act, cmpl_s, ilock_s, buzzer, operate_r};
        OFF_IRQ_ST: rdata_r <= {28'h0, irq_st_r};
        OFF_IRQ_MASK: rdata_r <= {28'h0, irq_mask_r};
        OFF_CMD: rdata_r <= '0;
        default: begin
          rdata_r <= '0;
          rresp_r <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
endmodule

// >>> sim/ljx_top_checker.sv
module ljx_top_checker #(
  parameter int SHORT_CYC = 8,
  parameter int LONG_CYC = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic s_axi_wvalid,
  input wire logic result_valid,
  input wire logic meas_start,
  input wire logic meas_done,
  input wire logic period_done,
  input wire logic src_delay_start,
  input wire logic ilock_out,
  input wire logic ilock_oe,
  input wire logic cmpl_out,
  input wire logic cmpl_oe,
  input wire logic operate,
  input wire logic meas_allow,
  input wire logic buzzer,
  input wire logic above_upper_limit,
  input wire logic pass_limits,
  input wire logic below_lower_limit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] jv;
  logic done, trig, cause;
  int low_cnt_r;
  assign jv = {above_upper_limit, pass_limits, below_lower_limit};
  assign done = meas_done && period_done;
  assign trig = meas_start || src_delay_start || result_valid || done;
  assign cause = s_axi_wvalid || result_valid;
  default clocking
    @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////
  // Length of the current low run on the complete line
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) low_cnt_r <= '0;
    else if (cmpl_oe && !cmpl_out) low_cnt_r <= low_cnt_r + 1;
    else low_cnt_r <= '0;
  end
  ////////////////////////////////
  AST_JUDGE_ONEHOT: assert property ($onehot0(jv))
    else $error("judgement outputs overlap");
  AST_JUDGE_CAUSE: assert property (
    ($rose(jv[2]) || $rose(jv[1]) || $rose(jv[0])) |-> $past(result_valid))
    else $error("judgement without result");
  AST_JUDGE_HOLD: assert property (
    $changed(jv) |-> $past(cause) || $past(cause, 2) || $past(cause, 3))
    else $error("judgement changed alone");
  AST_BUZ_JUDGE: assert property (buzzer |-> jv != 3'h0)
    else $error("buzzer without judgement");
  AST_OPOUT_LEVEL: assert property (ilock_oe |-> ilock_out == !operate)
    else $error("operate line level wrong");
  AST_BUSY_IN_DIR: assert property (!meas_allow |-> !cmpl_oe)
    else $error("stall while driving line");
  AST_DIR_HOLD: assert property (
    $changed({ilock_oe, cmpl_oe}) |-> $past(cause) || $past(cause, 2) || $past(cause, 3))
    else $error("line direction changed alone");
  AST_PULSE_WIDTH: assert property (
    $rose(cmpl_out) && cmpl_oe && $past(cmpl_oe) && !$past(done) && !$past(done, 2)
    |-> low_cnt_r >= SHORT_CYC)
    else $error("complete pulse too short");
  AST_CMPL_CAUSE: assert property (
    $fell(cmpl_out) && cmpl_oe && $past(cmpl_oe)
    |-> $past(trig) || $past(trig, 2) || $past(trig, 3))
    else $error("complete pulse without trigger");
  COV_HIGH_BUZ: cover property (jv[2] && buzzer);
  COV_LONG: cover property ($rose(cmpl_out) && low_cnt_r == LONG_CYC);
  COV_STALL: cover property (!meas_allow);
endmodule

bind ljx_top ljx_top_checker #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) chk_u (
  .clk(clk), .rst_n(rst_n), .s_axi_wvalid(s_axi_wvalid), .result_valid(result_valid),
  .meas_start(meas_start), .meas_done(meas_done), .period_done(period_done),
  .src_delay_start(src_delay_start), .ilock_out(ilock_out), .ilock_oe(ilock_oe),
  .cmpl_out(cmpl_out), .cmpl_oe(cmpl_oe), .operate(operate), .meas_allow(meas_allow),
  .buzzer(buzzer), .above_upper_limit(above_upper_limit), .pass_limits(pass_limits),
  .below_lower_limit(below_lower_limit)
);

// >>> sim/ljx_handler.sv
module ljx_handler (
  input wire logic ilock_out,
  input wire logic ilock_oe,
  input wire logic cmpl_out,
  input wire logic cmpl_oe,
  input wire logic ilock_drv,
  input wire logic ilock_lvl,
  input wire logic busy_hold,
  output logic ilock_in,
  output logic cmpl_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Open line floats high through the pull-up
  assign ilock_in = ilock_oe ? ilock_out : (ilock_drv ? ilock_lvl : 1'h1);
  // Handler holds the line low to stall the next step
  assign cmpl_in = cmpl_oe ? cmpl_out : !busy_hold;
endmodule

// >>> sim/ljx_top_tb.sv
module ljx_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ljx_pkg::*;
  localparam int SHORT_W = 8;
  localparam int LONG_W = 20;
  logic clk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, result_valid = 0, key_operate = 0;
  logic meas_start = 0, meas_done = 0, period_done = 0, src_delay_start = 0;
  logic ilock_drv = 0, ilock_lvl = 0, busy_hold = 0;
  logic [5:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, result_data = '0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rresp_v, bresp_v;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic ilock_in, ilock_out, ilock_oe, cmpl_in, cmpl_out, cmpl_oe, operate, irq;
  logic meas_allow, buzzer, above_upper_limit, pass_limits, below_lower_limit;
  logic [2:0] jv;
  logic [31:0] vals [5] = '{32'h65, 32'h64, 32'h0, 32'hffff_ff9c, 32'hffff_ff9b};
  logic [2:0] jexp [5] = '{3'h4, 3'h2, 3'h2, 3'h2, 3'h1};
  int bad_count = 0, n_compared = 0, w;
  assign jv = {above_upper_limit, pass_limits, below_lower_limit};
  ljx_top #(.SHORT_CYC(SHORT_W), .LONG_CYC(LONG_W)) dut_u (
    .clk(clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .result_valid(result_valid), .result_data(result_data), .key_operate(key_operate),
    .meas_start(meas_start), .meas_done(meas_done), .period_done(period_done),
    .src_delay_start(src_delay_start), .ilock_in(ilock_in), .ilock_out(ilock_out),
    .ilock_oe(ilock_oe), .cmpl_in(cmpl_in), .cmpl_out(cmpl_out), .cmpl_oe(cmpl_oe),
    .operate(operate), .meas_allow(meas_allow), .buzzer(buzzer),
    .above_upper_limit(above_upper_limit), .pass_limits(pass_limits),
    .below_lower_limit(below_lower_limit), .irq(irq)
  );
  ljx_handler far_u (
    .ilock_out(ilock_out), .ilock_oe(ilock_oe), .cmpl_out(cmpl_out), .cmpl_oe(cmpl_oe),
    .ilock_drv(ilock_drv), .ilock_lvl(ilock_lvl), .busy_hold(busy_hold),
    .ilock_in(ilock_in), .cmpl_in(cmpl_in)
  );
  always #4 clk = ~clk;
  ////////////////////////////////
  task close_out();
    if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wr(input logic [5:0] a, input logic [31:0] d);
    bit ad, dd;
    ad = 0;
    dd = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= '1;
    s_axi_wvalid <= '1;
    s_axi_bready <= '1;
    do begin
      @(posedge clk);
      if (!ad && s_axi_awready) begin
        ad = 1;
        s_axi_awvalid <= '0;
      end
      if (!dd && s_axi_wready) begin
        dd = 1;
        s_axi_wvalid <= '0;
      end
    end while (s_axi_bvalid !== 1'h1);
    bresp_v = s_axi_bresp;
    s_axi_bready <= '0;
    @(posedge clk);
  endtask
  task rd(input logic [5:0] a);
    bit ad;
    ad = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= '1;
    s_axi_rready <= '1;
    do begin
      @(posedge clk);
      if (!ad && s_axi_arready) begin
        ad = 1;
        s_axi_arvalid <= '0;
      end
    end while (s_axi_rvalid !== 1'h1);
    rdat = s_axi_rdata;
    rresp_v = s_axi_rresp;
    s_axi_rready <= '0;
    @(posedge clk);
  endtask
  // One-cycle event on the measurement side or on the operate key
  task fire(input int f, input logic [31:0] d);
    case (f)
      0: meas_start <= '1;
      1: begin
        meas_done <= '1;
        period_done <= '1;
      end
      5: src_delay_start <= '1;
      6: key_operate <= '1;
      7: meas_done <= '1;
      default: begin
        result_data <= d;
        result_valid <= '1;
      end
    endcase
    @(posedge clk);
    {meas_start, meas_done, period_done, src_delay_start, key_operate, result_valid} <= '0;
  endtask
  // Width of the next low pulse on the complete line
  task pw();
    int n;
    n = 0;
    w = 0;
    while (cmpl_out !== 1'h0 && n < 10) begin
      @(posedge clk);
      n++;
    end
    while (cmpl_out === 1'h0 && w < 100) begin
      @(posedge clk);
      w++;
    end
  endtask
  task lvl(input logic v, input logic e);
    ilock_lvl <= v;
    tick(6);
    chk("operate", 32'(e), 32'(operate));
  endtask
  ////////////////////////////////
  initial begin
    tick(20000);
    bad_count++;
    close_out();
  end
  initial begin
    tick(20);
    rst_n <= '1;
    tick(1);
    chk("line_oe", 32'h1, 32'({ilock_oe, cmpl_oe}));
    rd(OFF_CTRL);
    chk("ctrl", CTRL_RST, rdat);
    rd(6'h20);
    chk("rresp", 32'(RESP_SLVERR), 32'(rresp_v));
    wr(6'h24, 32'h1);
    chk("bresp", 32'(RESP_SLVERR), 32'(bresp_v));
    wr(OFF_UPPER, 32'h64);
    wr(OFF_LOWER, 32'hffff_ff9c);
    for (int i = 0; i < 5; i++) begin
      wr(OFF_CTRL, 32'h1);
      fire(2, vals[i]);
      tick(2);
      chk("judge", 32'(jexp[i]), 32'(jv));
      for (int m = 0; m < 4; m++) begin
        wr(OFF_CTRL, 32'h1 | 32'(m << 1));
        chk("buzzer", (m < 3) ? 32'(jexp[i][2 - m]) : 32'h0, 32'(buzzer));
      end
    end
    wr(OFF_CTRL, 32'h0);
    fire(2, vals[0]);
    tick(2);
    chk("judge_off", 32'h0, 32'(jv));
    for (int f = 0; f < 5; f++) begin
      wr(OFF_CTRL, 32'h1 | 32'(f << 8));
      fire((f + 1) % 5, vals[(2 * f + 8) % 5]);
      pw();
      chk("no_pulse", 32'h0, 32'(w));
      fire(f, vals[(2 * f + 6) % 5]);
      pw();
      chk("pulse", 32'(SHORT_W), 32'(w));
    end
    wr(OFF_CTRL, 32'h1000);
    fire(0, 32'h0);
    pw();
    chk("pulse_long", 32'(LONG_W), 32'(w));
    wr(OFF_CTRL, 32'h500);
    chk("busy_in_oe", 32'h0, 32'(cmpl_oe));
    busy_hold <= '1;
    tick(5);
    chk("allow_lo", 32'h0, 32'(meas_allow));
    busy_hold <= '0;
    tick(5);
    chk("allow_hi", 32'h1, 32'(meas_allow));
    wr(OFF_CTRL, 32'h600);
    fire(5, 32'h0);
    tick(12);
    fire(7, 32'h0);
    tick(3);
    chk("busy_on", 32'h0, 32'(cmpl_out));
    fire(1, 32'h0);
    tick(3);
    chk("busy_off", 32'h1, 32'(cmpl_out));
    wr(OFF_CTRL, 32'h30);
    wr(OFF_CMD, 32'h1);
    tick(2);
    chk("op_out", 32'h5, 32'({ilock_oe, ilock_out, operate}));
    wr(OFF_CMD, 32'h2);
    tick(2);
    chk("op_stby", 32'h6, 32'({ilock_oe, ilock_out, operate}));
    ilock_drv <= '1;
    wr(OFF_CTRL, 32'h0);
    wr(OFF_CMD, 32'h1);
    tick(2);
    lvl('1, '0);
    lvl('0, '0);
    wr(OFF_CTRL, 32'h10);
    lvl('1, '0);
    lvl('0, '1);
    lvl('1, '0);
    wr(OFF_CTRL, 32'h20);
    ilock_drv <= '0;
    tick(6);
    fire(6, 32'h0);
    wr(OFF_CMD, 32'h1);
    tick(2);
    chk("refused", 32'h0, 32'(operate));
    rd(OFF_IRQ_ST);
    chk("irq_st", 32'h8, rdat & 32'h8);
    chk("irq_off", 32'h0, 32'(irq));
    wr(OFF_IRQ_MASK, 32'h8);
    tick(1);
    chk("irq_on", 32'h1, 32'(irq));
    wr(OFF_IRQ_ST, 32'h8);
    tick(1);
    chk("irq_clr", 32'h0, 32'(irq));
    ilock_drv <= '1;
    lvl('0, '0);
    fire(6, 32'h0);
    tick(2);
    chk("op_ok", 32'h1, 32'(operate));
    lvl('1, '0);
    close_out();
  end
endmodule
